// ==== src/wdts_top.v ====
/*
  watchdog supervisor: control register with timed unlock, fuse-selected
  safety level, prescaled timeout counter on a 1 MHz tick enable, one-cycle
  chip reset pulse, reset cause flag and a masked timeout interrupt.
  assumes: one clock i_mclk at 50 MHz, synchronous active-high reset i_srst
  that stands for power-on reset, a cpu on the same clock driving the
  register port and the restart pulse, fuse levels arriving from pins.
*/
// Operation
// RL1: counter advances on a 1 MHz oscillator tick separate from cpu clock; here a tick enable divided down from i_mclk.
// RL2: restart instruction clears the counter, starting a fresh period.
// RL3: counter cleared while disabled and on any chip reset.
// RL4: enabled counter reaching selected period issues a chip reset.
// RL5: fuses give level 1, 0 with compat fuse, 2 with always-on fuse.
// RL6: writing one to enable always enables, no sequence needed; here a write in the timeout cycle is lost at levels 0 and 1.
// RL7: prescaler change needs unlock bit at levels 1 and 2, free at 0.
// RL8: control bits seven to five read as zero.
// RL9: unlock bit at bit four self-clears four cpu clocks after written.
// RL10: enable bit three; zero disables only while unlock bit is set.
// RL11: software writes unlock and enable together, then zero within four clocks.
// RL12: level 2 keeps watchdog enabled, ignoring every disable attempt.
// RL13: prescaler bits two to zero select 16384 doubling to 2097152 ticks.
// RL14: timeout gives a one cpu clock reset pulse; delay starts at its fall.
// RL15: watchdog reset sets flag bit three; power-on or written zero clears it.
// RL16: at level 2 the enable bit always reads one.
// RL17: restart, enable and prescale updates cross to tick domain without loss.
`timescale 1ns/100ps
`include "wdts_consts.vh"

module wdts_top #(
  parameter OSC_DIV = `WDTS_MCLK_HZ / `WDTS_OSC_HZ,
  parameter BASE_TICKS = `WDTS_BASE_TICKS,
  parameter UNLOCK_CYC = `WDTS_UNLOCK_CYC
) (
  // clock and reset
  input wire i_mclk,
  input wire i_srst,
  // fuse pins, one means programmed
  input wire i_always_on_fuse,
  input wire i_legacy_compat_fuse,
  // cpu restart instruction
  input wire i_restart,
  // register port
  input wire [`WDTS_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // system outputs
  output reg o_chip_rst,
  output reg o_irq,
  output reg o_wd_enabled,
  output reg [1:0] o_safety_level
);

  localparam CNT_W = 22;
  localparam DIV_W = 8;
  localparam UNL_W = 3;

  // period in oscillator ticks for a prescaler code
  function [CNT_W-1:0] period_ticks;
    input [2:0] sel;
    begin
      period_ticks = BASE_TICKS[CNT_W-1:0] << sel;
    end
  endfunction

  // fuse level to safety level
  function [1:0] level_of;
    input aon;
    input compat;
    begin
      if (aon)
        level_of = `WDTS_LVL_2;
      else if (compat)
        level_of = `WDTS_LVL_0;
      else
        level_of = `WDTS_LVL_1;
    end
  endfunction

  // fuse synchronisers
  reg [1:0] aon_sync_reg;
  reg [1:0] compat_sync_reg;

  always @(posedge i_mclk) begin
    aon_sync_reg <= {aon_sync_reg[0], i_always_on_fuse};
    compat_sync_reg <= {compat_sync_reg[0], i_legacy_compat_fuse};
  end

  wire [1:0] lvl_now = level_of(aon_sync_reg[1], compat_sync_reg[1]);

  // state
  reg [1:0] level_reg;
  reg en_reg;
  reg unlock_reg;
  reg [UNL_W-1:0] unlock_cnt_reg;
  reg [2:0] psel_reg;
  reg [DIV_W-1:0] div_reg;
  reg tick_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg toflag_reg;
  reg irq_stat_reg;
  reg irq_mask_reg;

  wire wr_ctrl = i_wr && (i_addr == `WDTS_OFF_CTRL);
  wire wr_rstat = i_wr && (i_addr == `WDTS_OFF_RSTAT);
  wire wr_istat = i_wr && (i_addr == `WDTS_OFF_IRQ_STAT);
  wire wr_imask = i_wr && (i_addr == `WDTS_OFF_IRQ_MASK);
  wire lvl2 = (level_reg == `WDTS_LVL_2);

  // timeout when the last tick of the period arrives while enabled
  wire timeout = en_reg && tick_reg && !i_restart &&
                 (cnt_reg == period_ticks(psel_reg) - {{(CNT_W-1){1'b0}}, 1'b1});

  // level caught while reset is held
  always @(posedge i_mclk) begin
    if (i_srst)
      level_reg <= lvl_now; // RL5
  end

  // oscillator tick enable, one cycle every OSC_DIV clocks
  always @(posedge i_mclk) begin
    if (i_srst) begin
      div_reg <= {DIV_W{1'b0}};
      tick_reg <= 1'b0;
    end else if (div_reg == OSC_DIV[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1}) begin
      div_reg <= {DIV_W{1'b0}};
      tick_reg <= 1'b1; // RL1
    end else begin
      div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_reg <= 1'b0;
    end
  end

  // control register: enable, unlock window, prescaler
  always @(posedge i_mclk) begin
    if (i_srst) begin
      en_reg <= (lvl_now == `WDTS_LVL_2); // RL5
      unlock_reg <= 1'b0;
      unlock_cnt_reg <= {UNL_W{1'b0}};
      psel_reg <= `WDTS_PSEL_RST;
    end else if (timeout) begin
      en_reg <= lvl2;
      unlock_reg <= 1'b0;
      unlock_cnt_reg <= {UNL_W{1'b0}};
      psel_reg <= `WDTS_PSEL_RST;
    end else begin
      if (wr_ctrl && i_wdata[`WDTS_BIT_UNLOCK]) begin
        unlock_reg <= 1'b1;
        unlock_cnt_reg <= UNLOCK_CYC[UNL_W-1:0];
      end else if (unlock_reg) begin
        if (unlock_cnt_reg == {{(UNL_W-1){1'b0}}, 1'b1})
          unlock_reg <= 1'b0; // RL9
        unlock_cnt_reg <= unlock_cnt_reg - {{(UNL_W-1){1'b0}}, 1'b1};
      end
      if (lvl2)
        en_reg <= 1'b1; // RL12
      else if (wr_ctrl && i_wdata[`WDTS_BIT_EN])
        en_reg <= 1'b1; // RL6
      else if (wr_ctrl && unlock_reg)
        en_reg <= 1'b0; // RL10
      if (wr_ctrl && ((level_reg == `WDTS_LVL_0) || unlock_reg))
        psel_reg <= i_wdata[`WDTS_PSEL_HI:`WDTS_PSEL_LO]; // RL7
    end
  end

  // timeout counter in oscillator ticks
  always @(posedge i_mclk) begin
    if (i_srst)
      cnt_reg <= {CNT_W{1'b0}}; // RL3
    else if (!en_reg || timeout)
      cnt_reg <= {CNT_W{1'b0}}; // RL3
    else if (i_restart)
      cnt_reg <= {CNT_W{1'b0}}; // RL2
    else if (tick_reg)
      cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // RL13
  end

  // reset cause flag and interrupt, set wins over clear
  always @(posedge i_mclk) begin
    if (i_srst) begin
      toflag_reg <= 1'b0; // RL15
      irq_stat_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
    end else begin
      if (timeout)
        toflag_reg <= 1'b1; // RL15
      else if (wr_rstat && !i_wdata[`WDTS_BIT_TOFLAG])
        toflag_reg <= 1'b0; // RL15
      if (timeout)
        irq_stat_reg <= 1'b1;
      else if (wr_istat && i_wdata[`WDTS_BIT_IRQ_TO])
        irq_stat_reg <= 1'b0;
      if (wr_imask)
        irq_mask_reg <= i_wdata[`WDTS_BIT_IRQ_TO];
    end
  end

  // outputs straight from flops
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_chip_rst <= 1'b0;
      o_irq <= 1'b0;
      o_wd_enabled <= 1'b0;
      o_safety_level <= `WDTS_LVL_1;
    end else begin
      o_chip_rst <= timeout; // RL4 RL14
      o_irq <= irq_stat_reg && irq_mask_reg;
      o_wd_enabled <= en_reg;
      o_safety_level <= level_reg;
    end
  end

  // read data one cycle after the strobe
  always @(posedge i_mclk) begin
    if (i_srst)
      o_rdata <= 8'h00;
    else if (i_rd) begin
      o_rdata <= 8'h00; // RL8
      case (i_addr)
        `WDTS_OFF_CTRL: begin
          o_rdata[`WDTS_BIT_UNLOCK] <= unlock_reg;
          o_rdata[`WDTS_BIT_EN] <= en_reg | lvl2; // RL16
          o_rdata[`WDTS_PSEL_HI:`WDTS_PSEL_LO] <= psel_reg;
        end
        `WDTS_OFF_RSTAT: begin
          o_rdata[`WDTS_BIT_TOFLAG] <= toflag_reg;
        end
        `WDTS_OFF_IRQ_STAT: begin
          o_rdata[`WDTS_BIT_IRQ_TO] <= irq_stat_reg;
        end
        `WDTS_OFF_IRQ_MASK: begin
          o_rdata[`WDTS_BIT_IRQ_TO] <= irq_mask_reg;
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else
      o_rdata <= 8'h00;
  end

  // single clock domain: restart, enable and prescale act in the same
  // cycle they are written, so no update can be lost on the way
  // RL17

endmodule

// ==== shared/wdts_consts.vh ====
/*
  constants for the watchdog supervisor: register offsets, field positions,
  reset values and timing figures.
  assumes: included by bare name from the design file, once or more.
*/
`ifndef WDTS_CONSTS_VH
`define WDTS_CONSTS_VH

// register word offsets on the plain register port
`define WDTS_ADDR_W 4
`define WDTS_OFF_CTRL 4'h0
`define WDTS_OFF_RSTAT 4'h1
`define WDTS_OFF_IRQ_STAT 4'h2
`define WDTS_OFF_IRQ_MASK 4'h3

// watchdog_control fields
`define WDTS_BIT_UNLOCK 4
`define WDTS_BIT_EN 3
`define WDTS_PSEL_HI 2
`define WDTS_PSEL_LO 0
`define WDTS_PSEL_RST 3'h0

// reset_cause_status fields
`define WDTS_BIT_TOFLAG 3

// interrupt status / mask fields
`define WDTS_BIT_IRQ_TO 0

// safety levels
`define WDTS_LVL_0 2'h0
`define WDTS_LVL_1 2'h1
`define WDTS_LVL_2 2'h2

// timing
`define WDTS_MCLK_HZ 50000000
`define WDTS_OSC_HZ 1000000
`define WDTS_BASE_TICKS 16384
`define WDTS_UNLOCK_CYC 4

`endif

// ==== tb/wdts_props.sv ====
/*
  port assertions for the watchdog supervisor.
  assumes: bound to wdts_top, one clock, OSC_DIV*BASE_TICKS above 7.
*/
`timescale 1ns/100ps
module wdts_props #(
  parameter OSC_DIV = 2,
  parameter BASE_TICKS = 4
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_restart,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_chip_rst,
  input wire o_wd_enabled,
  input wire [1:0] o_safety_level
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_rst_pulse_one: assert property (o_chip_rst |=> !o_chip_rst)
    else $error("reset pulse too long");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside slot");
  a_rsv_zero: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[7:5] == 3'h0)
    else $error("reserved bits set");
  a_lvl2_reads_en: assert property (i_rd && i_addr == 4'h0 && o_safety_level == 2'h2 |=> o_rdata[3])
    else $error("enable reads zero");
  a_lvl2_stays_on: assert property (o_safety_level == 2'h2 |-> o_wd_enabled)
    else $error("level two disabled");
  a_en_write_sets: assert property (i_wr && i_addr == 4'h0 && i_wdata[3] ##1 !o_chip_rst |=> o_wd_enabled)
    else $error("enable write ignored");
  a_off_no_rst: assert property (!o_wd_enabled [*3] |-> !o_chip_rst)
    else $error("reset while disabled");
  a_restart_holds: assert property (i_restart |-> ##2 !o_chip_rst [*5])
    else $error("reset soon after restart");
  a_unmapped_zero: assert property (i_rd && i_addr > 4'h3 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ==== tb/wdts_cpu.sv ====
/*
  cpu model: register port master and restart pulses.
  assumes: shares the watchdog clock, read data one cycle after the strobe.
*/
`timescale 1ns/100ps
module wdts_cpu (
  input wire i_clk,
  input wire [7:0] i_rdata,
  output logic [3:0] o_addr = 4'h0,
  output logic [7:0] o_wdata = 8'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic o_restart = 1'b0
);
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= v;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    v = i_rdata;
  endtask
  task restart;
    @(posedge i_clk);
    o_restart <= 1'b1;
    @(posedge i_clk);
    o_restart <= 1'b0;
  endtask
  // unlock with enable, clear inside the window, let the window close
  task disable_seq;
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    repeat (4) @(posedge i_clk);
  endtask
endmodule

// ==== tb/tb_top.sv ====
/*
  self-checking bench for the watchdog supervisor.
  assumes: design built with short tick divider and base count.
*/
`timescale 1ns/100ps
module tb_top;
  localparam OD = 2;
  localparam BT = 4;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic aon = 1'b0;
  logic cmp = 1'b0;
  wire [3:0] addr;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire wr, rd, rs, chip_rst, irq, wd_en;
  wire [1:0] lvl;
  logic [7:0] d;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  // compat fuse, always-on fuse, level, enabled after reset and after disable
  logic [4:0] rows [4] = '{5'b10000, 5'b01101, 5'b11101, 5'b00010};
  always #10 i_mclk = ~i_mclk;
  wdts_top #(.OSC_DIV(OD), .BASE_TICKS(BT)) u_wdts_top (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_always_on_fuse(aon), .i_legacy_compat_fuse(cmp), .i_restart(rs), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_chip_rst(chip_rst),
    .o_irq(irq), .o_wd_enabled(wd_en), .o_safety_level(lvl));
  wdts_cpu u_wdts_cpu (.i_clk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd), .o_restart(rs));
  task chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task do_reset(input logic c, input logic a);
    cmp <= c;
    aon <= a;
    i_srst <= 1'b1;
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset(rows[i][4], rows[i][3]);
      chk8({6'h00, lvl}, {6'h00, rows[i][2:1]});
      chk1(wd_en, rows[i][0]);
      u_wdts_cpu.wr(4'h0, 8'h0F);
      u_wdts_cpu.rd(4'h0, d);
      chk8(d, {5'h01, rows[i][2:1] == 2'h0 ? 3'h7 : 3'h0});
      u_wdts_cpu.disable_seq();
      u_wdts_cpu.rd(4'h0, d);
      chk8(d, {4'h0, rows[i][0], 3'h0});
      $display("fuse row %0d done", i);
    end
    u_wdts_cpu.wr(4'h0, 8'h18);
    u_wdts_cpu.rd(4'h0, d);
    chk8(d, 8'h18);
    u_wdts_cpu.restart();
    u_wdts_cpu.wr(4'h0, 8'h00);
    u_wdts_cpu.restart();
    u_wdts_cpu.rd(4'h0, d);
    chk8(d, 8'h08);
    u_wdts_cpu.disable_seq();
    u_wdts_cpu.rd(4'h9, d);
    chk8(d, 8'h00);
    $display("unlock window test done");
    for (int k = 0; k < 2; k++) begin
      u_wdts_cpu.wr(4'h3, {7'h00, k == 0});
      u_wdts_cpu.wr(4'h0, 8'h18);
      u_wdts_cpu.wr(4'h0, {5'h01, k == 0 ? 3'h0 : 3'h7});
      repeat (3) begin
        u_wdts_cpu.restart();
        repeat (3) @(posedge i_mclk);
      end
      u_wdts_cpu.restart();
      n = 0;
      while (chip_rst !== 1'b1 && n < 1300) begin
        @(posedge i_mclk);
        #1;
        n++;
      end
      if (n == 1300) begin
        num_errors++;
        give_verdict;
      end
      chk1(n >= ((BT << 7 * k) - 1) * OD && n <= (BT << 7 * k) * OD + 2, 1'b1);
      u_wdts_cpu.rd(4'h1, d);
      chk8(d, 8'h08);
      chk1(irq, k == 0);
      u_wdts_cpu.wr(4'h1, 8'h00);
      u_wdts_cpu.wr(4'h2, 8'h01);
      u_wdts_cpu.rd(4'h1, d);
      chk8(d, 8'h00);
      chk1(irq, 1'b0);
      chk1(wd_en, 1'b0);
      $display("timeout test %0d done", k);
    end
    give_verdict;
  end
endmodule
bind wdts_top wdts_props #(.OSC_DIV(OSC_DIV), .BASE_TICKS(BASE_TICKS)) u_wdts_props (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_restart(i_restart), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_chip_rst(o_chip_rst),
  .o_wd_enabled(o_wd_enabled), .o_safety_level(o_safety_level));
